// ### verilog/comparator_control_logic.sv
// Register file, reference decode and interrupt logic of the comparator.
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
module comparator_control_logic #(
   parameter bit SMALL_PACKAGE = 1'b0
) (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic cmp_high_raw_in,
   input wire logic cmp_low_raw_in,
   output logic positive_input_select_out,
   output logic negative_input_select_out,
   output logic ref_enable_out,
   output logic [5:0] reference_level_out,
   output logic [11:0] ref_level_mv_out,
   output logic ref_reserved_out,
   output logic power_down_out,
   output logic comparator_out,
   output logic comparator_pin_out,
   output logic comparator_pin_oe_out,
   output logic irq_out
);

   // ----------------------------------------------------------------
   // Register storage.
   // ----------------------------------------------------------------
   logic [7:0] ctrl_ff;
   logic [7:0] power_ff;
   logic [1:0] status_ff;
   logic [1:0] mask_ff;
   logic [7:0] rdata_ff;
   logic [11:0] ref_mv_ff;
   logic reserved_ff;
   logic [5:0] level_code_ff;

   // ----------------------------------------------------------------
   // Address decode.
   // ----------------------------------------------------------------
   logic hit_ctrl;
   logic hit_power;
   logic hit_status;
   logic hit_mask;
   logic hit_state;
   logic ctrl_wr;
   logic power_wr;
   logic status_wr;
   logic mask_wr;

   assign hit_ctrl = (reg_addr_in == comparator_control_pkg::CTRL_OFFSET);
   assign hit_power = (reg_addr_in == comparator_control_pkg::POWER_OFFSET);
   assign hit_status =
      (reg_addr_in == comparator_control_pkg::STATUS_OFFSET);
   assign hit_mask = (reg_addr_in == comparator_control_pkg::MASK_OFFSET);
   assign hit_state = (reg_addr_in == comparator_control_pkg::STATE_OFFSET);

   // Write strobes for each writable register.
   assign ctrl_wr = reg_wr_in && hit_ctrl;
   assign power_wr = reg_wr_in && hit_power;
   assign status_wr = reg_wr_in && hit_status;
   assign mask_wr = reg_wr_in && hit_mask;

   // ----------------------------------------------------------------
   // Decision stage.
   // ----------------------------------------------------------------
   comparator_decision_if dec_if ();

   // The analog decisions go straight to the synchronisers.
   assign dec_if.high_raw = cmp_high_raw_in;
   assign dec_if.low_raw = cmp_low_raw_in;
   assign dec_if.enable =
      !power_ff[comparator_control_pkg::PWR_DOWN_BIT];

   comparator_decision u_decision (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .dec (dec_if.core)
   );

   // ----------------------------------------------------------------
   // Reference level decode.
   // ----------------------------------------------------------------
   logic [3:0] coarse_code;
   logic [1:0] fine_code;
   logic [5:0] small_code;
   logic [11:0] large_mv;
   logic [11:0] small_mv;
   logic large_rsv;
   logic small_rsv;
   logic [11:0] nxt_ref_mv;
   logic nxt_reserved;
   logic [5:0] nxt_level_code;

   // Coarse and fine fields taken only from the comparator's own register.
   assign coarse_code = ctrl_ff[comparator_control_pkg::LEVEL_HI:
      comparator_control_pkg::LEVEL_LO];
   assign fine_code = ctrl_ff[comparator_control_pkg::FINE_HI:
      comparator_control_pkg::FINE_LO];
   assign small_code = {coarse_code, fine_code};

   // Linear levels; the products stay below the 12-bit range.
   assign large_mv = 12'({8'h00, coarse_code} *
      comparator_control_pkg::STEP_LARGE_MV);
   assign small_mv = 12'({6'h00, small_code} *
      comparator_control_pkg::STEP_SMALL_MV);
   assign large_rsv = (coarse_code > comparator_control_pkg::MAX_LARGE_CODE);
   assign small_rsv = (small_code > comparator_control_pkg::MAX_SMALL_CODE);

   // A reserved code is flagged and the level is held at the top step.
   assign nxt_ref_mv = SMALL_PACKAGE ?
      (small_rsv ? 12'({6'h00, comparator_control_pkg::MAX_SMALL_CODE} *
         comparator_control_pkg::STEP_SMALL_MV) : small_mv) :
      (large_rsv ? 12'({8'h00, comparator_control_pkg::MAX_LARGE_CODE} *
         comparator_control_pkg::STEP_LARGE_MV) : large_mv);
   assign nxt_reserved = SMALL_PACKAGE ? small_rsv : large_rsv;

   // The large package ignores the two low bits entirely.
   assign nxt_level_code = SMALL_PACKAGE ? small_code :
      {coarse_code, 2'b00};

   // Registered reference outputs.
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ref_mv_ff <= 12'h000;
         reserved_ff <= 1'b0;
         level_code_ff <= 6'h00;
      end else begin
         ref_mv_ff <= nxt_ref_mv;
         reserved_ff <= nxt_reserved;
         level_code_ff <= nxt_level_code;
      end
   end

   // ----------------------------------------------------------------
   // Control and power registers.
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl_ff <= comparator_control_pkg::CTRL_RESET;
         power_ff <= comparator_control_pkg::POWER_RESET;
         mask_ff <= comparator_control_pkg::MASK_RESET;
      end else begin
         if (ctrl_wr) begin
            ctrl_ff <= reg_wdata_in;
         end
         if (power_wr) begin
            power_ff <= reg_wdata_in & 8'h03;
         end
         if (mask_wr) begin
            mask_ff <= reg_wdata_in[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Sticky event bits: a new event wins over a clear in one cycle.
   // ----------------------------------------------------------------
   logic [1:0] evt_set;

   assign evt_set[comparator_control_pkg::EVT_RISE_BIT] = dec_if.rise;
   assign evt_set[comparator_control_pkg::EVT_FALL_BIT] = dec_if.fall;

   // One flop per event bit, cleared by writing a one.
   genvar gi;
   generate
      for (gi = 0; gi < comparator_control_pkg::EVT_W; gi++) begin : g_evt
         always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               status_ff[gi] <= comparator_control_pkg::STATUS_RESET[gi];
            end else if (evt_set[gi]) begin
               status_ff[gi] <= 1'b1;
            end else if (status_wr && reg_wdata_in[gi]) begin
               status_ff[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Level interrupt while any unmasked event bit is set.
   assign irq_out = |(status_ff & mask_ff);

   // ----------------------------------------------------------------
   // Read data path.
   // ----------------------------------------------------------------
   logic [7:0] state_word;
   logic [7:0] rd_mux;

   // Live state: output level, reserved-code flag, powered flag.
   assign state_word = {5'h00, dec_if.enable, reserved_ff, dec_if.state};

   // Unmapped addresses read as zero.
   assign rd_mux = hit_ctrl ? ctrl_ff :
      hit_power ? power_ff :
      hit_status ? {6'h00, status_ff} :
      hit_mask ? {6'h00, mask_ff} :
      hit_state ? state_word : 8'h00;

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= reg_rd_in ? rd_mux : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------
   assign reg_rdata_out = rdata_ff;
   assign positive_input_select_out =
      ctrl_ff[comparator_control_pkg::POS_SEL_BIT];
   assign negative_input_select_out =
      ctrl_ff[comparator_control_pkg::NEG_SEL_BIT];
   assign ref_enable_out = ctrl_ff[comparator_control_pkg::NEG_SEL_BIT] &&
      dec_if.enable;
   assign reference_level_out = level_code_ff;
   assign ref_level_mv_out = ref_mv_ff;
   assign ref_reserved_out = reserved_ff;
   assign power_down_out =
      power_ff[comparator_control_pkg::PWR_DOWN_BIT];
   assign comparator_out = dec_if.state;
   assign comparator_pin_out = dec_if.state;
   assign comparator_pin_oe_out =
      power_ff[comparator_control_pkg::PIN_ROUTE_BIT];

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   a_pos_select: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      ctrl_wr |=> (positive_input_select_out == $past(reg_wdata_in[7])))
      else $error("Positive select does not follow the write.");

   a_neg_select: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      (ctrl_wr && !power_ff[0]) |=>
      (ref_enable_out == $past(reg_wdata_in[6])))
      else $error("Reference enable does not follow the write.");

   // Level checks skip the edges where the level flops are still in reset.
   a_ref_large: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      (!SMALL_PACKAGE && !$past(sys_rst_in) && coarse_code <= 4'h9) |=>
      (ref_level_mv_out == 12'($past(coarse_code)) * 12'h0c8))
      else $error("Large package level is wrong.");

   a_ref_small: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      (SMALL_PACKAGE && !$past(sys_rst_in) && small_code <= 6'h24) |=>
      (ref_level_mv_out == 12'($past(small_code)) * 12'h032))
      else $error("Small package level is wrong.");

   a_low_bits_ignored: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      (!SMALL_PACKAGE && !$past(sys_rst_in) && $stable(ctrl_ff[7:2])) |=>
      $stable(ref_level_mv_out))
      else $error("Low control bits moved the level.");

   a_irq_raised: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      (dec_if.rise && mask_ff[0] && !mask_wr) |=> irq_out)
      else $error("Unmasked rise raised no interrupt.");

   a_power_quiet: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      power_ff[0] |=> (!dec_if.rise && !dec_if.fall && !comparator_out))
      else $error("Powered-down comparator produced events.");

   a_ref_own_setting: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      ($changed(ref_level_mv_out) && !$past(sys_rst_in, 2)) |->
      $past(ctrl_wr, 2))
      else $error("Level changed without a control write.");

   a_set_wins: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      (dec_if.rise && status_wr && reg_wdata_in[0]) |=> status_ff[0])
      else $error("Clear won over a new event.");

   a_fall_event: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      dec_if.fall |=> status_ff[1])
      else $error("A fall left no pending event.");

   a_clear_event: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      (status_wr && reg_wdata_in[0] && !dec_if.rise) |=> !status_ff[0])
      else $error("Writing a one did not clear the rise event.");

   a_level_code: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      !SMALL_PACKAGE |-> (reference_level_out[1:0] == 2'b00))
      else $error("Low level bits reached the large package code.");

   a_reserved_flag: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      (!SMALL_PACKAGE && ctrl_wr && reg_wdata_in[5:2] > 4'h9) |=>
      ##1 ref_reserved_out)
      else $error("Reserved level code was not flagged.");

endmodule // comparator_control_logic

// ### verilog/comparator_control_pkg.sv
// Constants, register map and field layout of the comparator control block.
package comparator_control_pkg;

   // ----------------------------------------------------------------
   // Register bus widths.
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;

   // ----------------------------------------------------------------
   // Register offsets.
   // ----------------------------------------------------------------
   localparam logic [11:0] CTRL_OFFSET = 12'hf90;
   localparam logic [11:0] POWER_OFFSET = 12'hf91;
   localparam logic [11:0] STATUS_OFFSET = 12'hf92;
   localparam logic [11:0] MASK_OFFSET = 12'hf93;
   localparam logic [11:0] STATE_OFFSET = 12'hf94;

   // ----------------------------------------------------------------
   // Reset values.
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h14;
   localparam logic [7:0] POWER_RESET = 8'h00;
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;

   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   localparam int POS_SEL_BIT = 7;
   localparam int NEG_SEL_BIT = 6;
   localparam int LEVEL_HI = 5;
   localparam int LEVEL_LO = 2;
   localparam int FINE_HI = 1;
   localparam int FINE_LO = 0;
   localparam int PWR_DOWN_BIT = 0;
   localparam int PIN_ROUTE_BIT = 1;
   localparam int EVT_RISE_BIT = 0;
   localparam int EVT_FALL_BIT = 1;
   localparam int EVT_W = 2;
   localparam int STATE_OUT_BIT = 0;
   localparam int STATE_RSV_BIT = 1;
   localparam int STATE_ON_BIT = 2;

   // ----------------------------------------------------------------
   // Reference level coding, in millivolts.
   // ----------------------------------------------------------------
   localparam logic [11:0] STEP_LARGE_MV = 12'h0c8;
   localparam logic [11:0] STEP_SMALL_MV = 12'h032;
   localparam logic [3:0] MAX_LARGE_CODE = 4'h9;
   localparam logic [5:0] MAX_SMALL_CODE = 6'h24;
   localparam logic [5:0] DEFAULT_SMALL_CODE = 6'h14;

endpackage

// ### verilog/comparator_decision_if.sv
// Signals between the register logic and the output decision stage.
`timescale 1ns/100ps
interface comparator_decision_if;
   logic high_raw;
   logic low_raw;
   logic enable;
   logic state;
   logic rise;
   logic fall;

   modport ctrl (output high_raw, output low_raw, output enable,
      input state, input rise, input fall);
   modport core (input high_raw, input low_raw, input enable,
      output state, output rise, output fall);
endinterface

// ### verilog/comparator_decision.sv
// Synchroniser, retained output state and transition pulses.
`timescale 1ns/100ps
module comparator_decision (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   comparator_decision_if.core dec
);

   logic high_meta_ff;
   logic high_sync_ff;
   logic low_meta_ff;
   logic low_sync_ff;
   logic state_ff;
   logic nxt_state;
   logic rise_ff;
   logic fall_ff;

   // Next retained state: high wins past hysteresis high, low past low.
   assign nxt_state = !dec.enable ? 1'b0 :
      (high_sync_ff && !low_sync_ff) ? 1'b1 :
      (low_sync_ff && !high_sync_ff) ? 1'b0 : state_ff;

   // --------------------------------------------------------------
   // Two-stage synchronisers for the asynchronous analog decisions.
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         high_meta_ff <= 1'b0;
         high_sync_ff <= 1'b0;
         low_meta_ff <= 1'b0;
         low_sync_ff <= 1'b0;
      end else begin
         high_meta_ff <= dec.high_raw;
         high_sync_ff <= high_meta_ff;
         low_meta_ff <= dec.low_raw;
         low_sync_ff <= low_meta_ff;
      end
   end

   // Retained state and one pulse per transition while enabled.
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_ff <= 1'b0;
         rise_ff <= 1'b0;
         fall_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         rise_ff <= dec.enable && nxt_state && !state_ff;
         fall_ff <= dec.enable && !nxt_state && state_ff;
      end
   end

   assign dec.state = state_ff;
   assign dec.rise = rise_ff;
   assign dec.fall = fall_ff;

   a_state_hold: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      (dec.enable && !high_sync_ff && !low_sync_ff) |=> $stable(state_ff))
      else $error("Retained state changed without a decision.");

   a_single_request: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      rise_ff |=> !rise_ff)
      else $error("One transition gave two requests.");

endmodule // comparator_decision

// ### tb/comparator_analog_model.sv
// Behavioural analog comparator core with input selection and hysteresis.
`timescale 1ns/100ps
module comparator_analog_model #(
   parameter int HYST_MV = 20
) (
   input wire logic positive_input_select_in,
   input wire logic negative_input_select_in,
   input wire logic ref_enable_in,
   input wire logic [11:0] ref_level_mv_in,
   input wire logic power_down_in,
   input wire integer pin_pos_mv_in,
   input wire integer pin_neg_mv_in,
   input wire integer temp_mv_in,
   output logic high_raw_out,
   output logic low_raw_out
);
   integer pos_mv;
   integer neg_mv;

   // The positive side takes the pin or the temperature sensor.
   assign pos_mv = positive_input_select_in ?
      temp_mv_in : pin_pos_mv_in;
   // The reference drives the negative side only while it is enabled.
   assign neg_mv = (negative_input_select_in && ref_enable_in) ?
      integer'(ref_level_mv_in) : pin_neg_mv_in;
   // Decisions lag the inputs; a powered-down core decides nothing.
   assign #15 high_raw_out = !power_down_in &&
      (pos_mv > neg_mv + HYST_MV);
   assign #15 low_raw_out = !power_down_in &&
      (neg_mv > pos_mv + HYST_MV);
endmodule // comparator_analog_model

// ### tb/comparator_control_logic_tb_top.sv
// Self-checking bench for the comparator control block.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("Error %s expected %0h seen %0h", nm, e, g); \
   end \
end
module comparator_control_logic_tb_top;
   logic sys_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] rdata, rdata_s, d, ds;
   logic high_raw, low_raw, pos_sel, neg_sel, ref_en, reserved, pdown;
   logic cmp_out, pin_out, pin_oe, irq, reserved_s;
   logic [5:0] level, level_s;
   logic [11:0] ref_mv, ref_mv_s, e_l, e_s;
   integer pin_pos = 0;
   integer pin_neg = 0;
   integer temp = 0;
   int failures = 0;
   int checks_done = 0;

   // ------------------------------------------------------------
   // Clock, devices and the analog partner.
   // ------------------------------------------------------------
   always #20 sys_clk_in = ~sys_clk_in;

   comparator_control_logic #(.SMALL_PACKAGE(1'b0)) i_dut (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
      .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
      .cmp_high_raw_in(high_raw), .cmp_low_raw_in(low_raw),
      .positive_input_select_out(pos_sel),
      .negative_input_select_out(neg_sel), .ref_enable_out(ref_en),
      .reference_level_out(level), .ref_level_mv_out(ref_mv),
      .ref_reserved_out(reserved), .power_down_out(pdown),
      .comparator_out(cmp_out), .comparator_pin_out(pin_out),
      .comparator_pin_oe_out(pin_oe), .irq_out(irq));

   // Second device with six-bit level coding, used for decode checks.
   comparator_control_logic #(.SMALL_PACKAGE(1'b1)) i_dut_small (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
      .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata_s),
      .cmp_high_raw_in(1'b0), .cmp_low_raw_in(1'b0),
      .positive_input_select_out(), .negative_input_select_out(),
      .ref_enable_out(), .reference_level_out(level_s),
      .ref_level_mv_out(ref_mv_s), .ref_reserved_out(reserved_s),
      .power_down_out(), .comparator_out(), .comparator_pin_out(),
      .comparator_pin_oe_out(), .irq_out());

   comparator_analog_model i_core (
      .positive_input_select_in(pos_sel),
      .negative_input_select_in(neg_sel), .ref_enable_in(ref_en),
      .ref_level_mv_in(ref_mv), .power_down_in(pdown),
      .pin_pos_mv_in(pin_pos), .pin_neg_mv_in(pin_neg),
      .temp_mv_in(temp), .high_raw_out(high_raw), .low_raw_out(low_raw));

   // ------------------------------------------------------------
   // Bus cycles and waits.
   // ------------------------------------------------------------
   task wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge sys_clk_in);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk_in);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task rd(input logic [11:0] a);
      @(posedge sys_clk_in);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk_in);
      reg_rd <= 1'b0;
      #1;
      d = rdata;
      ds = rdata_s;
   endtask

   // Lets written values reach the registered reference outputs.
   task settle();
      repeat (2) @(posedge sys_clk_in);
      #1;
   endtask

   task wait_state(input logic e);
      int n;
      n = 0;
      while (cmp_out !== e && n < 12) begin
         @(posedge sys_clk_in);
         #1;
         n++;
      end
      `CHK("comparator_out", e, cmp_out)
      settle();
   endtask

   // ------------------------------------------------------------
   // Scenarios.
   // ------------------------------------------------------------
   task test_reset();
      rd(comparator_control_pkg::CTRL_OFFSET);
      `CHK("ctrl reset", 8'h14, d)
      `CHK("ctrl reset small", 8'h14, ds)
      @(posedge sys_clk_in);
      #1;
      `CHK("rdata idle", 8'h00, rdata)
      rd(comparator_control_pkg::POWER_OFFSET);
      `CHK("power reset", 8'h00, d)
      rd(comparator_control_pkg::MASK_OFFSET);
      `CHK("mask reset", 8'h00, d)
      rd(12'hf95);
      `CHK("unmapped read", 8'h00, d)
      `CHK("level default", 6'h14, level_s)
      `CHK("mv default", 12'h3e8, ref_mv)
      `CHK("mv default small", 12'h3e8, ref_mv_s)
      $display("test_reset done");
   endtask

   task test_selects();
      for (int i = 0; i < 4; i++) begin
         wr(comparator_control_pkg::CTRL_OFFSET, {i[1:0], 6'h14});
         settle();
         `CHK("positive select", i[1], pos_sel)
         `CHK("negative select", i[0], neg_sel)
         `CHK("ref enable", i[0], ref_en)
      end
      wr(comparator_control_pkg::POWER_OFFSET, 8'h01);
      settle();
      `CHK("power down", 1'b1, pdown)
      `CHK("ref enable off", 1'b0, ref_en)
      wr(comparator_control_pkg::POWER_OFFSET, 8'h00);
      $display("test_selects done");
   endtask

   task test_levels();
      for (int c = 0; c < 64; c++) begin
         wr(comparator_control_pkg::CTRL_OFFSET, {2'b00, c[5:0]});
         settle();
         e_l = (c[5:2] > 4'h9) ? 12'h708 : 12'(c[5:2] * 12'hc8);
         e_s = (c[5:0] > 6'h24) ? 12'h708 : 12'(c[5:0] * 12'h32);
         `CHK("level mv", e_l, ref_mv)
         `CHK("level code", {c[5:2], 2'b00}, level)
         `CHK("reserved", c[5:2] > 4'h9, reserved)
         `CHK("level mv small", e_s, ref_mv_s)
         `CHK("level code small", c[5:0], level_s)
         `CHK("reserved small", c[5:0] > 6'h24, reserved_s)
         rd(comparator_control_pkg::CTRL_OFFSET);
         `CHK("ctrl readback", {2'b00, c[5:0]}, d)
      end
      $display("test_levels done");
   endtask

   task test_compare();
      // Interrupts stay masked while the core is set up.
      wr(comparator_control_pkg::MASK_OFFSET, 8'h00);
      wr(comparator_control_pkg::CTRL_OFFSET, 8'h54);
      pin_pos = 500;
      settle();
      wait_state(1'b0);
      wr(comparator_control_pkg::STATUS_OFFSET, 8'h03);
      wr(comparator_control_pkg::MASK_OFFSET, 8'h03);
      wr(comparator_control_pkg::POWER_OFFSET, 8'h02);
      pin_pos = 1500;
      wait_state(1'b1);
      `CHK("irq on rise", 1'b1, irq)
      `CHK("pin value", 1'b1, pin_out)
      `CHK("pin enable", 1'b1, pin_oe)
      rd(comparator_control_pkg::STATUS_OFFSET);
      `CHK("status rise", 8'h01, d)
      rd(comparator_control_pkg::STATE_OFFSET);
      `CHK("state word", 8'h05, d)
      wr(comparator_control_pkg::STATUS_OFFSET, 8'h01);
      pin_pos = 1010;
      repeat (10) @(posedge sys_clk_in);
      #1;
      `CHK("hold in band", 1'b1, cmp_out)
      `CHK("irq cleared", 1'b0, irq)
      rd(comparator_control_pkg::STATUS_OFFSET);
      `CHK("one request", 8'h00, d)
      pin_pos = 500;
      wait_state(1'b0);
      `CHK("irq on fall", 1'b1, irq)
      wr(comparator_control_pkg::MASK_OFFSET, 8'h01);
      settle();
      `CHK("fall masked", 1'b0, irq)
      wr(comparator_control_pkg::STATUS_OFFSET, 8'h03);
      temp = 1300;
      wr(comparator_control_pkg::CTRL_OFFSET, 8'hd4);
      wait_state(1'b1);
      rd(comparator_control_pkg::STATUS_OFFSET);
      `CHK("status temp", 8'h01, d)
      wr(comparator_control_pkg::STATUS_OFFSET, 8'h01);
      $display("test_compare done");
   endtask

   task test_power();
      wr(comparator_control_pkg::POWER_OFFSET, 8'h01);
      settle();
      `CHK("off state", 1'b0, cmp_out)
      rd(comparator_control_pkg::STATE_OFFSET);
      `CHK("off state word", 8'h00, d)
      rd(comparator_control_pkg::STATUS_OFFSET);
      `CHK("off no event", 8'h00, d)
      rd(comparator_control_pkg::POWER_OFFSET);
      `CHK("power readback", 8'h01, d)
      wr(comparator_control_pkg::POWER_OFFSET, 8'h00);
      // The clear lands in the very cycle in which the rise sets the event.
      repeat (2) @(posedge sys_clk_in);
      wr(comparator_control_pkg::STATUS_OFFSET, 8'h01);
      wait_state(1'b1);
      rd(comparator_control_pkg::STATUS_OFFSET);
      `CHK("set wins", 8'h01, d)
      `CHK("irq after power up", 1'b1, irq)
      $display("test_power done");
   endtask

   task results();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog.
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      test_reset();
      test_selects();
      test_levels();
      test_compare();
      test_power();
      results();
   end

   // The whole run needs some five hundred cycles; this cuts a hang.
   initial begin
      #800000;
      failures++;
      results();
   end
endmodule // comparator_control_logic_tb_top
